/* core/tff_map.svh */
// Register map, field positions, reset values and timing constants
`ifndef TFF_MAP_SVH
`define TFF_MAP_SVH
`define TFF_CTRL_OFS      8'h00
`define TFF_STATUS_OFS    8'h04
`define TFF_MASK_OFS      8'h08
`define TFF_TXDATA_OFS    8'h0C
`define TFF_RXDATA_OFS    8'h10
`define TFF_STATE_OFS     8'h14
`define TFF_CTRL_CODED    0
`define TFF_CTRL_DENS_LO  1
`define TFF_CTRL_WRITE    3
`define TFF_CTRL_MARK     4
`define TFF_CTRL_STEP     5
`define TFF_CTRL_CONT     6
`define TFF_CTRL_BACK     7
`define TFF_ST_PARITY     0
`define TFF_ST_PROGRAM    1
`define TFF_ST_RECDONE    2
`define TFF_ST_LINERX     3
`define TFF_ST_INHIBIT    4
`define TFF_ST_TXEMPTY    5
`define TFF_EV_W          6
`define TFF_TX_LAST       6
`define TFF_CTRL_RST      3'h0
`define TFF_MASK_RST      6'h00
`define TFF_CLK_HZ        250000000
`define TFF_IPS           150
`define TFF_BPI_800       800
`define TFF_BPI_556       556
`define TFF_BPI_200       200
`define TFF_GAP_MIL       750
`define TFF_FM_MIL        6000
`define TFF_RD_GAP_MIL    375
`define TFF_CHK_GAP_LINES 4
`define TFF_FM_CHAR       6'h0F
`define TFF_ILLEGAL_CHAR  6'h00
`endif

/* core/tff_pkg.sv */
// Types shared by the tape frame formatter
package tff_pkg;
	typedef enum logic [3:0] {
		S_IDLE    = 4'b0000,
		S_WDATA   = 4'b0001,
		S_WCHKGAP = 4'b0010,
		S_WCHK    = 4'b0011,
		S_WGAP    = 4'b0100,
		S_FMLEAD  = 4'b0101,
		S_FMDATA  = 4'b0110,
		S_READ    = 4'b0111,
		S_BACK    = 4'b1000
	} tff_state_type;
	typedef enum logic [1:0] {
		P_800_200 = 2'b00,
		P_800_556 = 2'b01,
		P_556_200 = 2'b10
	} tff_preset_type;
endpackage

/* core/tff_line_if.sv */
// Line coding signals between the formatter and its codec
`timescale 1ns/1ps
interface tff_line_if;
	logic [5:0] char_w;
	logic       coded;
	logic [6:0] line_w;
	logic [6:0] line_r;
	logic       par_ok;
	logic       illegal;
	modport codec (input char_w, coded, line_r,
		output line_w, par_ok, illegal);
	modport user (output char_w, coded, line_r,
		input line_w, par_ok, illegal);
endinterface

/* core/tff_line_codec.sv */
// Lateral parity generation and line checking
`timescale 1ns/1ps
`include "tff_map.svh"
module tff_line_codec
	import tff_pkg::*;
(
	tff_line_if.codec lif
);
	logic par_w;
	always_comb begin
		par_w = lif.coded ? ^lif.char_w : ~^lif.char_w;
		lif.line_w = {par_w, lif.char_w};
		lif.par_ok = lif.coded ? ~^lif.line_r : ^lif.line_r;
		lif.illegal = lif.coded &&
			(lif.line_r[5:0] == `TFF_ILLEGAL_CHAR);
	end
endmodule

/* core/tff_spacing.sv */
// Down counter giving a one-cycle pulse after a loaded count
`timescale 1ns/1ps
module tff_spacing #(
	parameter int W = 24
) (
	input  wire logic         ref_clk,
	input  wire logic         nrst,
	input  wire logic         load,
	input  wire logic [W-1:0] count,
	output logic              busy,
	output logic              done
);
	logic [W-1:0] cnt_q;
	always_ff @(posedge ref_clk) begin
		if (!nrst)
			cnt_q <= '0;
		else if (load)
			cnt_q <= count;
		else if (cnt_q != '0)
			cnt_q <= cnt_q - 1'b1;
	end
	always_ff @(posedge ref_clk) begin
		if (!nrst)
			done <= 1'b0;
		else
			done <= !load && (cnt_q == {{(W-1){1'b0}}, 1'b1});
	end
	assign busy = (cnt_q != '0);
endmodule

/* core/tff_top.sv */
// Seven-track tape formatter with AHB-Lite register slave
//
// Notes on behaviour
// - Each track toggles on a one bit, holds level on a zero bit.
// - A line is six character bits on tracks 0-5, parity on track 6.
// - Binary mode: parity makes the seven-bit line odd, checked on read.
// - Coded mode: parity makes the seven-bit line even, checked on read.
// - A control register bit, not the handler, picks binary or coded.
// - A record holds one or more lines; records sit three quarter inch apart.
// - Each record ends with a check line making every track count even.
// - File mark: six inches of tape, then coded 17 octal and its check line.
// - No ring means no writing; reading works either way.
// - Lateral parity failure or illegal coded character flags parity error.
// - Illegal coded character or backspace at load point flags program error.
// - Preset maps handler high/low request to 800/200, 800/556 or 556/200.
`timescale 1ns/1ps
`include "tff_map.svh"
module tff_top
	import tff_pkg::*;
#(
	parameter int unsigned LINE_800 = `TFF_CLK_HZ / (`TFF_BPI_800 * `TFF_IPS),
	parameter int unsigned LINE_556 = `TFF_CLK_HZ / (`TFF_BPI_556 * `TFF_IPS),
	parameter int unsigned LINE_200 = `TFF_CLK_HZ / (`TFF_BPI_200 * `TFF_IPS),
	parameter int unsigned GAP_CYC  =
		(`TFF_CLK_HZ / `TFF_IPS / 1000) * `TFF_GAP_MIL,
	parameter int unsigned FM_CYC   =
		(`TFF_CLK_HZ / `TFF_IPS / 1000) * `TFF_FM_MIL,
	parameter int unsigned RD_GAP   =
		(`TFF_CLK_HZ / `TFF_IPS / 1000) * `TFF_RD_GAP_MIL
) (
	input  wire logic        ref_clk,
	input  wire logic        nrst,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic [31:0]      hrdata,
	output logic             hresp,
	input  wire logic [6:0]  trk_in,
	input  wire logic        rd_strobe,
	input  wire logic        ring_in,
	input  wire logic        load_point_in,
	input  wire logic        dens_hi_in,
	output logic [6:0]       trk_out,
	output logic             wr_strobe,
	output logic             wr_enable,
	output logic             fwd,
	output logic             rev,
	output logic             irq
);
	tff_line_if lif ();
	tff_state_type st_q;
	logic [2:0]  ctrl_q;
	logic [5:0]  sts_q;
	logic [5:0]  mask_q;
	logic [6:0]  tx_q;
	logic        tx_valid_q;
	logic [6:0]  rx_q;
	logic [6:0]  lrc_q;
	logic [1:0]  gap_cnt_q;
	logic        step_q;
	logic [6:0]  trk_s1_q, trk_s2_q, trk_prev_q;
	logic [3:0]  pin_s1_q, pin_s2_q;
	logic        strobe_d_q;
	logic        ring_s, lp_s, hi_s, strobe_s, strobe_rise;
	logic        ap_wr_q;
	logic [7:0]  ap_addr_q;
	logic        ap_take;
	logic        wr_ctrl, wr_sts, wr_mask, wr_tx;
	logic [`TFF_EV_W-1:0] ev;
	logic [9:0]  bpi;
	logic [23:0] line_cyc;
	logic        line_busy, line_tick;
	logic        spc_load, spc_done;
	logic [23:0] spc_count;
	logic        emit;
	logic [6:0]  emit_line;
	logic        cmd_write, cmd_mark, cmd_step, cmd_cont, cmd_back;
	logic        rd_line_ok;

	// Pin synchronisers
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			trk_s1_q <= 7'h00;
			trk_s2_q <= 7'h00;
			pin_s1_q <= 4'h0;
			pin_s2_q <= 4'h0;
			strobe_d_q <= 1'b0;
		end else begin
			trk_s1_q <= trk_in;
			trk_s2_q <= trk_s1_q;
			pin_s1_q <= {rd_strobe, ring_in, load_point_in, dens_hi_in};
			pin_s2_q <= pin_s1_q;
			strobe_d_q <= strobe_s;
		end
	end
	assign {strobe_s, ring_s, lp_s, hi_s} = pin_s2_q;
	assign strobe_rise = strobe_s && !strobe_d_q;

	// Density preset and line time
	always_comb begin
		case (tff_preset_type'(ctrl_q[2:1]))
			P_800_200: bpi = hi_s ? 10'(`TFF_BPI_800) : 10'(`TFF_BPI_200);
			P_800_556: bpi = hi_s ? 10'(`TFF_BPI_800) : 10'(`TFF_BPI_556);
			P_556_200: bpi = hi_s ? 10'(`TFF_BPI_556) : 10'(`TFF_BPI_200);
			default:   bpi = 10'(`TFF_BPI_200);
		endcase
		case (bpi)
			10'(`TFF_BPI_800): line_cyc = 24'(LINE_800);
			10'(`TFF_BPI_556): line_cyc = 24'(LINE_556);
			default:           line_cyc = 24'(LINE_200);
		endcase
	end

	tff_spacing #(.W(24)) u_line (
		.ref_clk (ref_clk),
		.nrst    (nrst),
		.load    (line_tick || !line_busy),
		.count   (line_cyc),
		.busy    (line_busy),
		.done    (line_tick)
	);
	tff_spacing #(.W(24)) u_gap (
		.ref_clk (ref_clk),
		.nrst    (nrst),
		.load    (spc_load),
		.count   (spc_count),
		.busy    (),
		.done    (spc_done)
	);
	tff_line_codec u_codec (
		.lif (lif)
	);

	// Codec hookup; file mark is always coded
	assign lif.char_w = (st_q == S_FMDATA) ? `TFF_FM_CHAR : tx_q[5:0];
	assign lif.coded  = (st_q == S_FMDATA) || ctrl_q[`TFF_CTRL_CODED];
	assign lif.line_r = trk_s2_q ^ trk_prev_q;
	assign rd_line_ok = lif.par_ok && !lif.illegal;

	// AHB-Lite address phase
	assign ap_take = hsel && hready && htrans[1];
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			ap_wr_q <= 1'b0;
			ap_addr_q <= 8'h00;
		end else begin
			ap_wr_q <= ap_take && hwrite;
			ap_addr_q <= haddr[7:0];
		end
	end
	assign wr_ctrl = ap_wr_q && ap_addr_q == `TFF_CTRL_OFS;
	assign wr_sts  = ap_wr_q && ap_addr_q == `TFF_STATUS_OFS;
	assign wr_mask = ap_wr_q && ap_addr_q == `TFF_MASK_OFS;
	assign wr_tx   = ap_wr_q && ap_addr_q == `TFF_TXDATA_OFS;
	assign cmd_write = wr_ctrl && hwdata[`TFF_CTRL_WRITE];
	assign cmd_mark  = wr_ctrl && hwdata[`TFF_CTRL_MARK];
	assign cmd_step  = wr_ctrl && hwdata[`TFF_CTRL_STEP];
	assign cmd_cont  = wr_ctrl && hwdata[`TFF_CTRL_CONT];
	assign cmd_back  = wr_ctrl && hwdata[`TFF_CTRL_BACK];

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			hrdata <= 32'h0000_0000;
			hreadyout <= 1'b0;
			hresp <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			if (ap_take && !hwrite) begin
				case (haddr[7:0])
					`TFF_CTRL_OFS:   hrdata <= {29'h0, ctrl_q};
					`TFF_STATUS_OFS: hrdata <= {26'h0, sts_q};
					`TFF_MASK_OFS:   hrdata <= {26'h0, mask_q};
					`TFF_TXDATA_OFS: hrdata <= {24'h0, tx_valid_q, tx_q};
					`TFF_RXDATA_OFS: hrdata <= {25'h0, rx_q};
					`TFF_STATE_OFS:
						hrdata <= {14'h0, bpi, hi_s, lp_s, ring_s,
							tx_valid_q, st_q};
					default:         hrdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			ctrl_q <= `TFF_CTRL_RST;
			mask_q <= `TFF_MASK_RST;
		end else begin
			if (wr_ctrl)
				ctrl_q <= hwdata[2:0];
			if (wr_mask)
				mask_q <= hwdata[5:0];
		end
	end

	// Sticky status, set wins over write-one-to-clear
	always_ff @(posedge ref_clk) begin
		if (!nrst)
			sts_q <= 6'h00;
		else if (wr_sts)
			sts_q <= (sts_q & ~hwdata[5:0]) | ev;
		else
			sts_q <= sts_q | ev;
	end
	always_ff @(posedge ref_clk) begin
		if (!nrst)
			irq <= 1'b0;
		else
			irq <= |(sts_q & mask_q);
	end

	// Line emission to the heads
	assign emit = line_tick && ((st_q == S_WDATA && tx_valid_q) ||
		st_q == S_WCHK || st_q == S_FMDATA);
	assign emit_line = (st_q == S_WCHK) ? lrc_q : lif.line_w;
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			trk_out <= 7'h00;
			wr_strobe <= 1'b0;
		end else begin
			wr_strobe <= emit && ring_s;
			if (emit && ring_s)
				trk_out <= trk_out ^ emit_line;
		end
	end
	always_ff @(posedge ref_clk) begin
		if (!nrst)
			lrc_q <= 7'h00;
		else if (st_q == S_WCHK && line_tick)
			lrc_q <= 7'h00;
		else if (emit)
			lrc_q <= lrc_q ^ emit_line;
	end

	// Transmit holding register
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			tx_q <= 7'h00;
			tx_valid_q <= 1'b0;
		end else if (emit && st_q == S_WDATA) begin
			tx_valid_q <= 1'b0;
		end else if (wr_tx && !tx_valid_q) begin
			tx_q <= hwdata[6:0];
			tx_valid_q <= 1'b1;
		end
	end

	// Read line capture
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			trk_prev_q <= 7'h00;
			rx_q <= 7'h00;
		end else if (strobe_rise) begin
			trk_prev_q <= trk_s2_q;
			if (st_q == S_READ)
				rx_q <= lif.line_r;
		end
	end

	// Events
	always_comb begin
		ev = '0;
		ev[`TFF_ST_PARITY] = strobe_rise && st_q == S_READ &&
			!rd_line_ok;
		ev[`TFF_ST_PROGRAM] = (strobe_rise && st_q == S_READ &&
			lif.illegal) || (st_q == S_IDLE && cmd_back && lp_s);
		ev[`TFF_ST_RECDONE] = spc_done &&
			(st_q == S_WGAP || st_q == S_READ || st_q == S_BACK);
		ev[`TFF_ST_LINERX] = strobe_rise && st_q == S_READ;
		ev[`TFF_ST_INHIBIT] = st_q == S_IDLE && (cmd_write || cmd_mark) &&
			!ring_s;
		ev[`TFF_ST_TXEMPTY] = emit && st_q == S_WDATA;
	end

	// Gap and spacing timer loads
	always_comb begin
		spc_load = 1'b0;
		spc_count = 24'(GAP_CYC);
		if (st_q == S_IDLE && cmd_mark && ring_s) begin
			spc_load = 1'b1;
			spc_count = 24'(FM_CYC);
		end else if (st_q == S_WCHK && line_tick) begin
			spc_load = 1'b1;
			spc_count = 24'(GAP_CYC);
		end else if ((st_q == S_IDLE && (cmd_step || cmd_cont ||
			(cmd_back && !lp_s))) ||
			((st_q == S_READ || st_q == S_BACK) && strobe_rise)) begin
			spc_load = 1'b1;
			spc_count = 24'(RD_GAP);
		end
	end

	// Sequencer
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			st_q <= S_IDLE;
			gap_cnt_q <= 2'h0;
			step_q <= 1'b0;
		end else begin
			case (st_q)
				S_IDLE: begin
					gap_cnt_q <= 2'h0;
					if (cmd_write && ring_s)
						st_q <= S_WDATA;
					else if (cmd_mark && ring_s)
						st_q <= S_FMLEAD;
					else if (cmd_step || cmd_cont) begin
						st_q <= S_READ;
						step_q <= cmd_step;
					end else if (cmd_back && !lp_s)
						st_q <= S_BACK;
				end
				S_WDATA:
					if (emit && tx_q[`TFF_TX_LAST])
						st_q <= S_WCHKGAP;
				S_WCHKGAP:
					if (line_tick) begin
						gap_cnt_q <= gap_cnt_q + 2'h1;
						if (gap_cnt_q == 2'(`TFF_CHK_GAP_LINES - 1))
							st_q <= S_WCHK;
					end
				S_WCHK:
					if (line_tick)
						st_q <= S_WGAP;
				S_WGAP:
					if (spc_done)
						st_q <= S_IDLE;
				S_FMLEAD:
					if (spc_done)
						st_q <= S_FMDATA;
				S_FMDATA:
					if (line_tick)
						st_q <= S_WCHKGAP;
				S_READ:
					if (spc_done || (step_q && strobe_rise))
						st_q <= S_IDLE;
				S_BACK:
					if (spc_done)
						st_q <= S_IDLE;
				default:
					st_q <= S_IDLE;
			endcase
		end
	end

	// Handler motion and write gate
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			fwd <= 1'b0;
			rev <= 1'b0;
			wr_enable <= 1'b0;
		end else begin
			fwd <= st_q != S_IDLE && st_q != S_BACK;
			rev <= st_q == S_BACK;
			wr_enable <= ring_s && st_q != S_IDLE &&
				st_q != S_READ && st_q != S_BACK;
		end
	end
endmodule

/* test/tff_top_props.sv */
// Concurrent checks on the formatter's top-level ports
`timescale 1ns/1ps
module tff_top_props (
	input wire logic       ref_clk,
	input wire logic       nrst,
	input wire logic       hreadyout,
	input wire logic       hresp,
	input wire logic [6:0] trk_out,
	input wire logic       wr_strobe,
	input wire logic       wr_enable,
	input wire logic       fwd,
	input wire logic       rev,
	input wire logic       ring_in,
	input wire logic       load_point_in,
	input wire logic       irq
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	bus_okay_a: assert property (hresp == 1'b0)
		else $error("hresp not okay");
	zero_wait_a: assert property (nrst |=> hreadyout)
		else $error("hreadyout low out of reset");
	strobe_pulse_a: assert property (wr_strobe |=> !wr_strobe)
		else $error("wr_strobe longer than one cycle");
	flux_change_a: assert property (!$stable(trk_out) |-> wr_strobe)
		else $error("trk_out changed without a line");
	ring_block_a: assert property (
		(!ring_in) [*4] |-> !wr_strobe && !wr_enable)
		else $error("writing without ring");
	load_back_a: assert property (
		load_point_in [*4] |-> !$rose(rev))
		else $error("reverse at load point");
	motion_excl_a: assert property (!(fwd && rev))
		else $error("fwd and rev together");
	write_motion_a: assert property (wr_strobe |-> fwd)
		else $error("line written while stopped");
	cover property (wr_strobe);
	cover property ($rose(irq));
	cover property ($rose(fwd));
	cover property ($rose(rev));
endmodule

/* test/tff_tape.sv */
// Tape handler model: heads, ring, load point and density request
`timescale 1ns/1ps
module tff_tape (
	input  wire logic       ref_clk,
	input  wire logic [6:0] trk_out,
	input  wire logic       wr_strobe,
	output logic      [6:0] trk_in,
	output logic            rd_strobe,
	output logic            ring_in,
	output logic            load_point_in,
	output logic            dens_hi_in
);
	logic [6:0] wq [$];
	logic [6:0] last;
	initial begin
		trk_in = 7'h00;
		rd_strobe = 1'b0;
		ring_in = 1'b1;
		load_point_in = 1'b0;
		dens_hi_in = 1'b1;
		last = 7'h00;
	end
	// Decode written reversals into lines
	always @(posedge ref_clk) begin
		if (wr_strobe === 1'b1) begin
			wq.push_back(trk_out ^ last);
			last = trk_out;
		end
	end
	task automatic set(input logic r, input logic l, input logic d);
		ring_in <= r;
		load_point_in <= l;
		dens_hi_in <= d;
	endtask
	// Reverse track polarity on ones, then strobe
	task automatic send(input logic [6:0] l);
		trk_in <= trk_in ^ l;
		repeat (2) @(posedge ref_clk);
		rd_strobe <= 1'b1;
		repeat (2) @(posedge ref_clk);
		rd_strobe <= 1'b0;
		repeat (4) @(posedge ref_clk);
	endtask
endmodule

/* test/testbench.sv */
// Self-checking bench for the tape formatter
`timescale 1ns/1ps
`include "tff_map.svh"
module testbench;
	localparam logic [31:0] Z0 = 32'h0000_0000;
	localparam logic [31:0] ALL = 32'h0000_00FF;
	logic        ref_clk;
	logic        nrst;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic        hreadyout;
	logic [31:0] hrdata;
	logic        hresp;
	logic [6:0]  trk_in;
	logic [6:0]  trk_out;
	logic        rd_strobe;
	logic        ring_in;
	logic        load_point_in;
	logic        dens_hi_in;
	logic        wr_strobe;
	logic        wr_enable;
	logic        fwd;
	logic        rev;
	logic        irq;
	logic [31:0] rd;
	int          failures = 0;
	int          samples_checked = 0;
	int          cyc = 0;
	tff_top #(.LINE_200(8), .GAP_CYC(40), .FM_CYC(60), .RD_GAP(50)) u_dut (
		.ref_clk(ref_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
		.hresp(hresp), .trk_in(trk_in), .rd_strobe(rd_strobe),
		.ring_in(ring_in), .load_point_in(load_point_in),
		.dens_hi_in(dens_hi_in), .trk_out(trk_out), .wr_strobe(wr_strobe),
		.wr_enable(wr_enable), .fwd(fwd), .rev(rev), .irq(irq));
	tff_tape u_tape (
		.ref_clk(ref_clk), .trk_out(trk_out), .wr_strobe(wr_strobe),
		.trk_in(trk_in), .rd_strobe(rd_strobe), .ring_in(ring_in),
		.load_point_in(load_point_in), .dens_hi_in(dens_hi_in));
	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			failures++;
			final_report;
		end
	end
	task automatic final_report;
		$display("checks %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, g);
		samples_checked++;
		if (g !== e) begin
			$display("unexpected %s expected %h seen %h", n, e, g);
			failures++;
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h00_0000, a};
		htrans <= 2'h2;
		hwrite <= w;
		hsize <= 3'h2;
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task automatic wait_st(input logic [31:0] m, input int lim);
		for (int i = 0; i < lim; i++) begin
			bus(1'b0, `TFF_STATUS_OFS, Z0);
			if ((rd & m) !== Z0) break;
		end
	endtask
	task automatic t_regs;
		logic [7:0] ofs [4] = '{`TFF_CTRL_OFS, `TFF_STATUS_OFS,
			`TFF_MASK_OFS, 8'hFC};
		foreach (ofs[i]) begin
			bus(1'b0, ofs[i], Z0);
			chk("reset value", Z0, rd);
		end
		bus(1'b1, 8'hFC, 32'hFFFF_FFFF);
		bus(1'b0, 8'hFC, Z0);
		chk("unmapped", Z0, rd);
		bus(1'b1, `TFF_MASK_OFS, 32'hFFFF_FFFF);
		bus(1'b0, `TFF_MASK_OFS, Z0);
		chk("mask", 32'h0000_003F, rd);
		bus(1'b1, `TFF_MASK_OFS, Z0);
		$display("regs done");
	endtask
	task automatic t_dens;
		int bpi [6] = '{800, 200, 800, 556, 556, 200};
		for (int i = 0; i < 6; i++) begin
			u_tape.set(1'b1, 1'b0, 1'((i % 2) == 0));
			bus(1'b1, `TFF_CTRL_OFS, 32'(i / 2) << 1);
			repeat (4) @(posedge ref_clk);
			bus(1'b0, `TFF_STATE_OFS, Z0);
			chk("bpi", 32'(bpi[i]), {22'h00_0000, rd[17:8]});
		end
		$display("density done");
	endtask
	task automatic t_reset;
		nrst <= 1'b0;
		repeat (5) @(posedge ref_clk);
		nrst <= 1'b1;
		repeat (3) @(posedge ref_clk);
		bus(1'b0, `TFF_CTRL_OFS, Z0);
		chk("ctrl after reset", Z0, rd);
		bus(1'b0, `TFF_STATE_OFS, Z0);
		chk("bpi after reset", 32'(`TFF_BPI_200), {22'h00_0000, rd[17:8]});
		$display("reset done");
	endtask
	task automatic t_write;
		logic [6:0] e;
		logic [5:0] c;
		c = 6'h15;
		for (int i = 0; i < 3; i++) begin
			e = (i == 2) ? 7'h0F : {(i == 1) ? ^c : ~^c, c};
			u_tape.wq.delete();
			bus(1'b1, `TFF_MASK_OFS, 32'(i == 1) << `TFF_ST_RECDONE);
			bus(1'b1, `TFF_CTRL_OFS, 32'(i == 1));
			if (i < 2) bus(1'b1, `TFF_TXDATA_OFS, 32'({1'b1, c}));
			bus(1'b1, `TFF_CTRL_OFS, 32'(i == 1) | ((i == 2) ? 16 : 8));
			wait_st(32'h0000_0004, 500);
			chk("lines", 32'h0000_0002, 32'(u_tape.wq.size()));
			chk("data line", 32'(e), 32'(u_tape.wq[0]));
			chk("check line", 32'(e), 32'(u_tape.wq[1]));
			chk("irq", 32'(i == 1), 32'(irq));
			bus(1'b1, `TFF_STATUS_OFS, ALL);
			repeat (2) @(posedge ref_clk);
			chk("irq clear", Z0, 32'(irq));
		end
		$display("write done");
	endtask
	task automatic t_ring;
		u_tape.wq.delete();
		u_tape.set(1'b0, 1'b0, 1'b1);
		repeat (4) @(posedge ref_clk);
		bus(1'b1, `TFF_TXDATA_OFS, 32'h0000_0041);
		bus(1'b1, `TFF_CTRL_OFS, 32'h0000_0008);
		repeat (100) @(posedge ref_clk);
		bus(1'b0, `TFF_STATUS_OFS, Z0);
		chk("inhibit", 32'h0000_0010, rd & 32'h0000_0010);
		chk("no lines", Z0, 32'(u_tape.wq.size()));
		bus(1'b1, `TFF_STATUS_OFS, ALL);
		$display("ring done");
	endtask
	task automatic t_read;
		logic [6:0] ln [3] = '{7'h15, 7'h55, 7'h00};
		logic [3:0] st [3] = '{4'h8, 4'h9, 4'hB};
		for (int i = 0; i < 3; i++) begin
			bus(1'b1, `TFF_CTRL_OFS, 32'(i == 2));
			bus(1'b1, `TFF_CTRL_OFS, 32'(i == 2) | 32'h0000_0020);
			u_tape.send(ln[i]);
			bus(1'b0, `TFF_STATUS_OFS, Z0);
			chk("read status", 32'(st[i]), rd & 32'h0000_000B);
			bus(1'b0, `TFF_RXDATA_OFS, Z0);
			chk("rx line", 32'(ln[i]), rd);
			bus(1'b1, `TFF_STATUS_OFS, ALL);
		end
		bus(1'b1, `TFF_CTRL_OFS, 32'h0000_0040);
		u_tape.send(7'h15);
		u_tape.send(7'h23);
		wait_st(32'h0000_0004, 100);
		chk("read to gap", 32'h0000_0004, rd & 32'h0000_0004);
		bus(1'b0, `TFF_RXDATA_OFS, Z0);
		chk("last line", 32'h0000_0023, rd);
		$display("read done");
	endtask
	task automatic t_back;
		u_tape.set(1'b1, 1'b1, 1'b1);
		repeat (4) @(posedge ref_clk);
		bus(1'b1, `TFF_CTRL_OFS, 32'h0000_0080);
		repeat (8) @(posedge ref_clk);
		bus(1'b0, `TFF_STATUS_OFS, Z0);
		chk("load point", 32'h0000_0002, rd & 32'h0000_0002);
		chk("no reverse", Z0, 32'(rev));
		bus(1'b1, `TFF_STATUS_OFS, ALL);
		u_tape.set(1'b1, 1'b0, 1'b1);
		repeat (4) @(posedge ref_clk);
		bus(1'b1, `TFF_CTRL_OFS, 32'h0000_0080);
		repeat (2) @(posedge ref_clk);
		chk("reverse", 32'h0000_0001, 32'(rev));
		wait_st(32'h0000_0004, 100);
		chk("back to gap", 32'h0000_0004, rd & 32'h0000_0006);
		$display("back done");
	endtask
	initial begin
		nrst = 1'b0;
		hsel = 1'b0;
		haddr = Z0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h0;
		hwdata = Z0;
		repeat (5) @(posedge ref_clk);
		nrst <= 1'b1;
		repeat (3) @(posedge ref_clk);
		t_regs;
		t_dens;
		t_reset;
		t_write;
		t_ring;
		t_read;
		t_back;
		final_report;
	end
endmodule
bind tff_top tff_top_props u_props (
	.ref_clk(ref_clk), .nrst(nrst), .hreadyout(hreadyout), .hresp(hresp),
	.trk_out(trk_out), .wr_strobe(wr_strobe), .wr_enable(wr_enable),
	.fwd(fwd), .rev(rev), .ring_in(ring_in),
	.load_point_in(load_point_in), .irq(irq));
